//--- ptc_client.sv
/*
 client model: sends one frame of beats, command on the first beat.
 assumes txReady is driven on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ptc_client
   import ptc_pkg::*;
(
   // clock and stall
   input wire logic core_clk,
   input wire logic txReady,
   // frame beats
   output var logic txValid,
   output var logic txLast,
   output var logic [CMD_W-1:0] txCmd
);
   initial
   begin
      txValid = 1'b0;
      txLast = 1'b0;
      txCmd = '0;
   end
   // later beats carry junk commands, since only the first beat counts
   task automatic send(input logic [CMD_W-1:0] cmd, input int n, output bit ok);
      int i;
      int g;
      bit beat;
      i = 0;
      g = 0;
      // no payload is modelled, so timestamp bytes under the udp checksum read as zero
      txValid = 1'b1;
      txCmd = cmd;
      txLast = (n == 1);
      while (i < n && g < 200)
      begin
         @(posedge core_clk);
         beat = txReady;
         @(negedge core_clk);
         g++;
         if (beat)
         begin
            i++;
            txCmd = {$urandom, $urandom};
            txLast = (i == n - 1);
         end
      end
      txValid = 1'b0;
      txLast = 1'b0;
      txCmd = ~txCmd; // idle bus shows no stale command
      ok = (i == n);
   endtask
endmodule
`default_nettype wire

//--- ptc_pkg.sv
/*
 package of the transmit precision-time command decoder: command word layout,
 operation codes, decoded control struct and offset and reset constants.
 assumes a single transmit clock and a client that presents the command with
 the first data beat of each frame.
*/
// Functional notes
// - operation field is bits 1:0; code 00 means no capture, frame untouched
// - code 01 is one-step: capture a timestamp and insert it into the frame
// - code 10 is two-step: capture, return timestamp, leave frame untouched
// - code 11 is reserved and behaves exactly like no-action
// - reserved bits 7:2 and 15:9 have no effect
// - checksum-update flag ignored for no-action and two-step
// - one-step with flag set recalculates UDP checksum; clear means none touched
// - one-step and two-step return the 16-bit tag with the timestamp
// - tag is ignored for no-action frames
// - timestamp offset ignored for no-action and two-step
// - time-of-day one-step inserts timestamp at offset counted from first DA byte
// - checksum offset ignored unless one-step with update flag set
// - correction format locates checksum a fixed distance before correction field
// - time-of-day one-step with update set takes checksum position from offset
// - correction format one-step adds 64-bit timestamp to existing correction
// - frame check sequence is computed after all one-step modifications
package ptc_pkg;
   localparam int CMD_W = 64;
   localparam int OP_LSB = 0;
   localparam int UPD_BIT = 8;
   localparam int TAG_LSB = 16;
   localparam int TSOFF_LSB = 32;
   localparam int CSOFF_LSB = 48;
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_ONE = 2'h1;
   localparam logic [1:0] OP_TWO = 2'h2;
   localparam logic [1:0] OP_RSVD = 2'h3;
   // bytes from udp checksum forward to the ptp correction field
   localparam logic [15:0] CF_CSUM_DIST = 16'h0010;
   localparam logic [15:0] OFF_RESET = 16'h0000;
   localparam logic [15:0] TAG_RESET = 16'h0000;

   typedef struct packed {
      logic capture;    // take a timestamp
      logic insert;     // modify the frame (one-step)
      logic giveBack;   // return timestamp and tag to client
      logic addCorr;    // sum into correction field
      logic csumUpd;    // rewrite udp checksum
      logic [15:0] tag;
      logic [15:0] tsOffset;
      logic [15:0] csumOffset;
   } ptc_ctrl_t;
endpackage

//--- ptc_tx_cmd_decoder.sv
/*
 transmit command decoder: latches the command word at the first beat of
 each frame and presents decoded controls to the mac transmit pipeline.
 assumes inputs synchronous to core_clk and an axi-stream style frame bus.
*/
`timescale 1ns/1ps
`default_nettype none
module ptc_tx_cmd_decoder
   import ptc_pkg::*;
#(
   parameter bit CORR_FORMAT = 1'b0
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // frame beat qualifiers from client
   input wire logic txValid,
   input wire logic txReady,
   input wire logic txLast,
   input wire logic [CMD_W-1:0] txCmd,
   // decoded controls to pipeline
   output logic ctrlValid,
   output var ptc_ctrl_t ctrl,
   output logic fcsAfterEdit
);
   // gray along idle to frame and back: one bit moves per step
   typedef enum logic [1:0] {S_IDLE = 2'b00, S_FRAME = 2'b01} ptc_state_t;

   ptc_state_t state;
   ptc_state_t next_state;
   logic beat;
   logic firstBeat;
   ptc_ctrl_t next_ctrl;

   // pure decode, used only by the latch; the checks restate each field themselves
   function automatic ptc_ctrl_t decode(input logic [CMD_W-1:0] c, input bit corr);
      ptc_ctrl_t d;
      logic [1:0] op;
      d = '0;
      op = c[OP_LSB +: 2];
      // reserved bits are never read
      case (op)
         OP_ONE:
         begin
            d.capture = 1'b1;
            d.insert = 1'b1;
            d.giveBack = 1'b1;
            d.addCorr = corr;
            d.tag = c[TAG_LSB +: 16];
            d.tsOffset = c[TSOFF_LSB +: 16];
            d.csumUpd = c[UPD_BIT];
            if (c[UPD_BIT])
            begin
               // correction build fixes the checksum distance, so the offset field is unused
               if (corr)
                  d.csumOffset = c[TSOFF_LSB +: 16] - CF_CSUM_DIST;
               else
                  d.csumOffset = c[CSOFF_LSB +: 16];
            end
         end
         OP_TWO:
         begin
            d.capture = 1'b1;
            d.giveBack = 1'b1;
            d.tag = c[TAG_LSB +: 16];
            // flag and offsets dropped
         end
         OP_NONE, OP_RSVD:
            d = '0;
         default:
            d = '0;
      endcase
      return d;
   endfunction

   // a beat is a transfer the pipeline actually took, stalls do not count
   assign beat = txValid && txReady;
   assign firstBeat = beat && (state == S_IDLE);

   // frame tracker: first beat of a multi-beat frame opens, last beat closes
   always_comb
   begin
      next_state = state;
      case (state)
         S_IDLE:
            if (beat && !txLast)
               next_state = S_FRAME;
         S_FRAME:
            if (beat && txLast)
               next_state = S_IDLE;
         default:
            next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= S_IDLE;
      else
         state <= next_state;
   end

   // command sampled only on first beat so later sideband noise cannot leak
   assign next_ctrl = firstBeat ? decode(txCmd, CORR_FORMAT) : ctrl;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= '0;
         ctrlValid <= 1'b0;
         fcsAfterEdit <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         // a single-beat frame never leaves idle, so an idle cycle without a
         // new first beat is what ends its one-cycle valid pulse
         if (firstBeat)
            ctrlValid <= 1'b1;
         else if (state == S_IDLE || (beat && txLast))
            ctrlValid <= 1'b0;
         // fcs must wait for every edit of a one-step frame
         fcsAfterEdit <= next_ctrl.insert;
      end
   end

   // checks
   property p_hold;
      @(posedge core_clk) disable iff (!rst_n)
      (state == S_FRAME && !firstBeat) |=> $stable(ctrl);
   endproperty
   a_hold: assert property (p_hold) else $error("ctrl changed mid frame");

   property p_none;
      @(posedge core_clk) disable iff (!rst_n)
      (firstBeat && (txCmd[1:0] == OP_NONE || txCmd[1:0] == OP_RSVD))
         |=> (ctrl == '0);
   endproperty
   a_none: assert property (p_none) else $error("no-action decoded active");

   property p_one;
      @(posedge core_clk) disable iff (!rst_n)
      (firstBeat && txCmd[1:0] == OP_ONE)
         |=> (ctrl.insert && ctrl.capture && ctrl.tag == $past(txCmd[31:16]));
   endproperty
   a_one: assert property (p_one) else $error("one-step decode wrong");

   property p_two;
      @(posedge core_clk) disable iff (!rst_n)
      (firstBeat && txCmd[1:0] == OP_TWO)
         |=> (ctrl.giveBack && !ctrl.insert && !ctrl.csumUpd && ctrl.tsOffset == '0);
   endproperty
   a_two: assert property (p_two) else $error("two-step decode wrong");

   property p_csum;
      @(posedge core_clk) disable iff (!rst_n)
      (firstBeat && txCmd[1:0] == OP_ONE && !CORR_FORMAT)
         |=> (ctrl.csumUpd == $past(txCmd[8]))
             && (ctrl.csumOffset == ($past(txCmd[8]) ? $past(txCmd[63:48]) : 16'h0000));
   endproperty
   a_csum: assert property (p_csum) else $error("checksum decode wrong");

   property p_fcs;
      @(posedge core_clk) disable iff (!rst_n)
      ##1 (fcsAfterEdit == ctrl.insert);
   endproperty
   a_fcs: assert property (p_fcs) else $error("fcs flag disagrees");

   property p_valid;
      @(posedge core_clk) disable iff (!rst_n)
      firstBeat |=> ctrlValid;
   endproperty
   a_valid: assert property (p_valid) else $error("valid missing");

   property p_close;
      @(posedge core_clk) disable iff (!rst_n)
      (beat && txLast && state == S_FRAME) |=> !ctrlValid;
   endproperty
   a_close: assert property (p_close) else $error("valid stuck");

   // a single-beat frame must not leave valid standing once the bus goes quiet
   property p_pulse;
      @(posedge core_clk) disable iff (!rst_n)
      (firstBeat && txLast) ##1 !beat |=> !ctrlValid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("valid outlived frame");

   // correction build: the checksum sits a fixed distance ahead of the field
   property p_corr;
      @(posedge core_clk) disable iff (!rst_n)
      (firstBeat && txCmd[1:0] == OP_ONE && CORR_FORMAT && txCmd[UPD_BIT])
         |=> (ctrl.csumOffset == $past(txCmd[TSOFF_LSB +: 16]) - CF_CSUM_DIST);
   endproperty
   a_corr: assert property (p_corr) else $error("checksum position wrong");

   property p_add;
      @(posedge core_clk) disable iff (!rst_n)
      firstBeat |=> (ctrl.addCorr == (CORR_FORMAT && $past(txCmd[1:0]) == OP_ONE));
   endproperty
   a_add: assert property (p_add) else $error("correction add flag wrong");

   property p_tag;
      @(posedge core_clk) disable iff (!rst_n)
      (firstBeat && txCmd[1:0] == OP_TWO) |=> (ctrl.tag == $past(txCmd[TAG_LSB +: 16]));
   endproperty
   a_tag: assert property (p_tag) else $error("two-step tag lost");

   // the insertion point passes through untouched for one-step frames
   property p_tsoff;
      @(posedge core_clk) disable iff (!rst_n)
      (firstBeat && txCmd[1:0] == OP_ONE)
         |=> (ctrl.tsOffset == $past(txCmd[TSOFF_LSB +: 16]));
   endproperty
   a_tsoff: assert property (p_tsoff) else $error("timestamp offset wrong");

   // scenarios worth seeing at least once
   c_one: cover property (@(posedge core_clk) firstBeat && txCmd[1:0] == OP_ONE);
   c_two: cover property (@(posedge core_clk) firstBeat && txCmd[1:0] == OP_TWO);
   c_rsvd: cover property (@(posedge core_clk) firstBeat && txCmd[1:0] == OP_RSVD);
   c_single: cover property (@(posedge core_clk) firstBeat && txLast);
   c_upd: cover property (@(posedge core_clk) firstBeat && txCmd[1:0] == OP_ONE && txCmd[UPD_BIT]);
endmodule
`default_nettype wire

//--- ptc_tx_cmd_decoder_test.sv
/*
 testbench of the command decoder: all op codes and flags, then random words.
 runs a time-of-day build and a correction-field build from one client.
*/
`timescale 1ns/1ps
`default_nettype none
module ptc_tx_cmd_decoder_test
   import ptc_pkg::*;
;
   logic core_clk, rst_n, txReady, txValid, txLast, ctrlValid, fcsAfterEdit;
   logic [CMD_W-1:0] txCmd;
   ptc_ctrl_t ctrl;
   ptc_ctrl_t ctrlCorr;
   logic ctrlValidCorr, fcsCorr;
   int failures, num_checks;
   ptc_client i_ptc_client (.core_clk(core_clk), .txReady(txReady), .txValid(txValid),
      .txLast(txLast), .txCmd(txCmd));
   ptc_tx_cmd_decoder #(.CORR_FORMAT(1'b0)) i_ptc_tx_cmd_decoder (.core_clk(core_clk),
      .rst_n(rst_n), .txValid(txValid), .txReady(txReady), .txLast(txLast), .txCmd(txCmd),
      .ctrlValid(ctrlValid), .ctrl(ctrl), .fcsAfterEdit(fcsAfterEdit));
   // second build in correction-field format, fed by the same client
   if (1'b1)
   begin : corr_build
      ptc_tx_cmd_decoder #(.CORR_FORMAT(1'b1)) i_ptc_tx_cmd_decoder (.core_clk(core_clk),
         .rst_n(rst_n), .txValid(txValid), .txReady(txReady), .txLast(txLast), .txCmd(txCmd),
         .ctrlValid(ctrlValidCorr), .ctrl(ctrlCorr), .fcsAfterEdit(fcsCorr));
   end
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // random stalls, one in four cycles
   always @(negedge core_clk) txReady <= ($urandom % 4) != 0;
   // bench's own frame tracker: valid stands from the cycle after a first beat
   // through the cycle of the last one, or for one cycle after a single-beat frame
   bit tbFrame;
   bit wantValid;
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         tbFrame = 1'b0;
         wantValid = 1'b0;
      end
      else if (txValid && txReady)
      begin
         wantValid = !tbFrame || !txLast;
         tbFrame = !txLast;
      end
      else
         wantValid = tbFrame;
   end
   always @(negedge core_clk)
   begin
      if (rst_n)
      begin
         chk_bit(ctrlValid, wantValid);
         chk_bit(ctrlValidCorr, wantValid);
      end
   end
   // fields a mode ignores are expected as zero
   function automatic ptc_ctrl_t exp_ctrl(input logic [CMD_W-1:0] c, input bit corr);
      ptc_ctrl_t e;
      logic one, two;
      e = '0;
      one = (c[1:0] == OP_ONE);
      two = (c[1:0] == OP_TWO);
      e.capture = one | two;
      e.insert = one;
      e.giveBack = one | two;
      e.csumUpd = one & c[UPD_BIT];
      e.tag = (one | two) ? c[31:16] : TAG_RESET;
      e.tsOffset = one ? c[47:32] : OFF_RESET;
      e.addCorr = one & corr;
      e.csumOffset = OFF_RESET;
      if (one & c[UPD_BIT])
         e.csumOffset = corr ? c[47:32] - CF_CSUM_DIST : c[63:48];
      return e;
   endfunction
   task automatic chk_ctrl(input ptc_ctrl_t got, input ptc_ctrl_t exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // first eight frames walk every op code with the flag clear and set
   initial
   begin
      logic [CMD_W-1:0] c;
      ptc_ctrl_t e;
      ptc_ctrl_t ec;
      bit ok;
      int n;
      failures = 0;
      num_checks = 0;
      rst_n = 1'b0;
      void'($urandom(32'h4196));
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      for (int k = 0; k < 16; k++)
      begin
         c = {$urandom, $urandom};
         if (k < 8)
         begin
            c[1:0] = k[1:0];
            c[UPD_BIT] = k[2];
         end
         c[TSOFF_LSB] = 1'b0;
         n = (k % 3 == 0) ? 1 : 1 + $urandom % 4;
         e = exp_ctrl(c, 1'b0);
         ec = exp_ctrl(c, 1'b1);
         i_ptc_client.send(c, n, ok);
         if (!ok)
         begin
            failures++;
            break;
         end
         // only a single-beat frame still shows valid in the cycle after its last beat
         chk_ctrl(ctrl, e);
         chk_ctrl(ctrlCorr, ec);
         chk_bit(ctrlValid, n == 1);
         chk_bit(ctrlValidCorr, n == 1);
         chk_bit(fcsAfterEdit, e.insert);
         chk_bit(fcsCorr, ec.insert);
         @(negedge core_clk);
         chk_bit(ctrlValid, 1'b0);
         chk_bit(ctrlValidCorr, 1'b0);
         chk_ctrl(ctrl, e);
         chk_ctrl(ctrlCorr, ec);
         $display("test %0d op %0d done", k, c[1:0]);
      end
      close_out();
   end
endmodule
`default_nettype wire
